/* design/dsh_device.sv */
`timescale 1ns/1ps
`include "dsh_consts.svh"
// ========================================
// decoder serial end
// Notes on behaviour
// - reset pin grounds both oscillator pins
// - layer 1/2 decode only when enabled
// - request low after 4096, high 6000 later
// - write frame: opcode, address, two data bytes
// - zero volume full level, all ones powerdown
// - read returns high then low byte
// - volume holds and returns all 16 bits
// - enter header starts sine test tone
// - exit bytes stop sine test
// - host frames each data byte with sync
// - sync marks first bit, rising edge sampling
// - wait for request, chunks at most 32
// - select pin gates chip select and clock
// - serial clock rests low when idle
// - host pin directions in reduced hookup
// - bit sync tied high only if safe
// - sustain highest stream bitrate decoding
module dsh_device
   import dsh_pkg::*;
(
   // link side, on link clock
   input  wire logic clk_link,
   dsh_link_if.device link,
   // user side
   input  wire logic clk,
   input  wire logic rst,
   output logic      sine_active_q,
   output logic      layer12_enable_q,
   output logic      analog_pdown_q,
   output logic [15:0] volume_q
);
   // ========================================
   // command port, on sclk
   typedef struct packed {
      logic [1:0]  bytes;
      logic [7:0]  op;
      logic [7:0]  addr;
      logic [7:0]  hi;
      logic [15:0] volume_reg;
      logic [15:0] mode;
      logic [15:0] out_sr;
      logic        vol_tgl;
   } dsh_cmd_st_t;
   dsh_cmd_st_t c_q, c_d;
   logic [7:0] cbyte;
   logic       cdone;
   logic       rst_any;
   assign rst_any = rst | ~link.hw_reset_n_pin;

   dsh_shift8 u_cmd_sh (
      .clk    (link.sclk),
      .rst    (rst_any),
      .clr    (link.ctrl_select_n),
      .shift  (~link.ctrl_select_n),
      .din    (link.mosi),
      .byte_q (cbyte),
      .done_q (cdone)
   );

   // decode each byte at the falling edge that ends it, so the last byte
   // of a frame lands before select rises; read data shifts out msb first
   always_comb
   begin
      c_d        = c_q;
      c_d.out_sr = {c_q.out_sr[14:0], 1'b0};
      if (link.ctrl_select_n)
      begin
         c_d.bytes = 2'h0;
      end
      else if (cdone)
      begin
         c_d.bytes = c_q.bytes + 2'h1;
         case (c_q.bytes)
            2'h0: c_d.op = cbyte;
            2'h1:
            begin
               c_d.addr = cbyte;
               if (c_q.op == `DSH_OP_READ)
               begin
                  c_d.out_sr = (cbyte == `DSH_ADDR_VOLUME) ? c_q.volume_reg :
                               (cbyte == `DSH_ADDR_MODE) ? c_q.mode : 16'h0000;
               end
            end
            2'h2: c_d.hi = cbyte;
            default:
            begin
               if (c_q.op == `DSH_OP_WRITE && c_q.addr == `DSH_ADDR_VOLUME)
               begin
                  c_d.volume_reg     = {c_q.hi, cbyte};
                  c_d.vol_tgl = ~c_q.vol_tgl;
               end
               if (c_q.op == `DSH_OP_WRITE && c_q.addr == `DSH_ADDR_MODE)
                  c_d.mode = {c_q.hi, cbyte};
            end
         endcase
      end
   end

   always_ff @(negedge link.sclk or posedge rst_any)
   begin
      if (rst_any)
      begin
         c_q      <= '0;
         c_q.volume_reg  <= `DSH_VOL_RESET;
      end
      else
         c_q <= c_d;
   end

   // bit 15 stands before the first dummy byte's first rising edge
   assign link.miso = c_q.out_sr[15];

   // ========================================
   // data port and wake-up, on link clock
   typedef struct packed {
      logic [63:0] hist;
      logic        sine;
      logic        sync_seen;
      logic [2:0]  cnt;
      logic [7:0]  sr;
      dsh_wake_st_t wst;
      logic [13:0] wcnt;
      logic        req;
   } dsh_dat_st_t;
   dsh_dat_st_t d_q, d_d;
   logic data_port_clock_s1_q, data_port_clock_s2_q, data_port_clock_s3_q;
   logic sync_s1_q, sync_s2_q, dat_s1_q, dat_s2_q, cs_s1_q, cs_s2_q;

   // data port bytes, sampled at data clock rising edge
   always_comb
   begin
      d_d = d_q;
      if (data_port_clock_s2_q && !data_port_clock_s3_q && cs_s2_q)
      begin
         if (sync_s2_q && !d_q.sync_seen)
         begin
            d_d.cnt       = 3'h1;
            d_d.sync_seen = 1'b1;
         end
         else
            d_d.cnt = d_q.cnt + 3'h1;
         d_d.sr = {d_q.sr[6:0], dat_s2_q};
         if (!sync_s2_q)
            d_d.sync_seen = 1'b0;
         if (d_d.cnt == 3'h0)
         begin
            d_d.hist = {d_q.hist[55:0], d_q.sr[6:0], dat_s2_q};
            if (d_d.hist == `DSH_SINE_ENTER)
               d_d.sine = 1'b1;
            if (d_q.sine && d_d.hist[31:0] == `DSH_SINE_EXIT)
               d_d.sine = 1'b0;
         end
      end
      // wake-up signature on request line
      case (d_q.wst)
         DSH_WAKE_WAIT:
         begin
            d_d.wcnt = d_q.wcnt + 14'h1;
            if (d_q.wcnt == 14'(`DSH_WAKE_LOW_CYC - 1))
            begin
               d_d.req  = 1'b0;
               d_d.wcnt = 14'h0;
               d_d.wst  = DSH_WAKE_LOW;
            end
         end
         DSH_WAKE_LOW:
         begin
            d_d.wcnt = d_q.wcnt + 14'h1;
            if (d_q.wcnt == 14'(`DSH_WAKE_HIGH_CYC - 1))
            begin
               d_d.req = 1'b1;
               d_d.wst = DSH_WAKE_DONE;
            end
         end
         default: d_d.req = 1'b1;
      endcase
   end

   always_ff @(posedge clk_link or posedge rst_any)
   begin
      if (rst_any)
      begin
         d_q       <= '0;
         d_q.wst   <= DSH_WAKE_WAIT;
         data_port_clock_s1_q <= 1'b0;
         data_port_clock_s2_q <= 1'b0;
         data_port_clock_s3_q <= 1'b0;
         sync_s1_q <= 1'b0;
         sync_s2_q <= 1'b0;
         dat_s1_q  <= 1'b0;
         dat_s2_q  <= 1'b0;
         cs_s1_q   <= 1'b0;
         cs_s2_q   <= 1'b0;
      end
      else
      begin
         d_q       <= d_d;
         data_port_clock_s1_q <= link.data_port_clock;
         data_port_clock_s2_q <= data_port_clock_s1_q;
         data_port_clock_s3_q <= data_port_clock_s2_q;
         sync_s1_q <= link.bit_sync;
         sync_s2_q <= sync_s1_q;
         dat_s1_q  <= link.mosi;
         dat_s2_q  <= dat_s1_q;
         cs_s1_q   <= link.ctrl_select_n;
         cs_s2_q   <= cs_s1_q;
      end
   end
   assign link.data_request = d_q.req;
   assign link.osc_out_pin  = 1'b0;
   assign link.osc_in_pin   = 1'b0;

   // ========================================
   // user side crossing on clk
   logic sine_s1_q, sine_s2_q, tgl_s1_q, tgl_s2_q, tgl_s3_q;
   logic l12_s1_q, l12_s2_q;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sine_s1_q        <= 1'b0;
         sine_s2_q        <= 1'b0;
         tgl_s1_q         <= 1'b0;
         tgl_s2_q         <= 1'b0;
         tgl_s3_q         <= 1'b0;
         l12_s1_q         <= 1'b0;
         l12_s2_q         <= 1'b0;
         sine_active_q    <= 1'b0;
         layer12_enable_q <= 1'b0;
         analog_pdown_q   <= 1'b1;
         volume_q         <= `DSH_VOL_RESET;
      end
      else
      begin
         sine_s1_q        <= d_q.sine;
         sine_s2_q        <= sine_s1_q;
         sine_active_q    <= sine_s2_q;
         tgl_s1_q         <= c_q.vol_tgl;
         tgl_s2_q         <= tgl_s1_q;
         tgl_s3_q         <= tgl_s2_q;
         l12_s1_q         <= c_q.mode[`DSH_MODE_L12_BIT];
         l12_s2_q         <= l12_s1_q;
         layer12_enable_q <= l12_s2_q;
         if (tgl_s2_q != tgl_s3_q)
         begin
            volume_q       <= c_q.volume_reg; // stable since toggle
            analog_pdown_q <= (c_q.volume_reg == `DSH_VOL_PDOWN);
         end
      end
   end
endmodule : dsh_device

/* common/dsh_consts.svh */
`ifndef DSH_CONSTS_SVH
`define DSH_CONSTS_SVH
// command opcodes and register addresses
`define DSH_OP_WRITE      8'h02
`define DSH_OP_READ       8'h03
`define DSH_ADDR_VOLUME   8'h0b
`define DSH_ADDR_MODE     8'h00
`define DSH_MODE_L12_BIT  2
`define DSH_VOL_RESET     16'hffff
`define DSH_VOL_FULL      16'h0000
`define DSH_VOL_PDOWN     16'hffff
// wake-up timing in link clock cycles
`define DSH_WAKE_LOW_CYC  4096
`define DSH_WAKE_HIGH_CYC 6000
// sine test headers
`define DSH_SINE_ENTER    64'h53ef6e3000000000
`define DSH_SINE_EXIT     32'h45786974
// host divider: last count of a half period, which lasts 4 clk cycles
`define DSH_DIV_HALF      4'd3
`define DSH_CHUNK_MAX     6'd32
`endif

/* common/dsh_pkg.sv */
package dsh_pkg;
   typedef enum logic [1:0] {DSH_IDLE, DSH_CMD, DSH_DATA} dsh_host_st_t;
   typedef enum logic [1:0] {DSH_WAKE_WAIT, DSH_WAKE_LOW, DSH_WAKE_DONE} dsh_wake_st_t;
endpackage : dsh_pkg

/* common/dsh_link_if.sv */
`timescale 1ns/1ps
interface dsh_link_if;
   logic sclk;
   logic mosi;
   logic miso;
   logic port_select_pin;
   logic bit_sync;
   logic data_request;
   logic hw_reset_n_pin;
   logic osc_out_pin;
   logic osc_in_pin;
   // and gate of the reduced-pin hookup
   wire  ctrl_select_n   = port_select_pin;
   wire  data_port_clock = sclk & port_select_pin;
   modport device (input sclk, mosi, ctrl_select_n, data_port_clock, bit_sync,
                   hw_reset_n_pin, output miso, data_request, osc_out_pin, osc_in_pin);
   modport host (output sclk, mosi, port_select_pin, bit_sync, hw_reset_n_pin,
                 input miso, data_request);
endinterface : dsh_link_if

/* design/dsh_shift8.sv */
`timescale 1ns/1ps
// msb-first byte shifter with bit counter
module dsh_shift8
   import dsh_pkg::*;
(
   // clock and clear
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       clr,
   // serial input
   input  wire logic       shift,
   input  wire logic       din,
   // byte output
   output logic [7:0]      byte_q,
   output logic            done_q
);
   typedef struct packed {
      logic [7:0] sr;
      logic [2:0] cnt;
      logic [7:0] byte_v;
      logic       done;
   } dsh_sh_st_t;
   dsh_sh_st_t s_q, s_d;

   // shift and count bits
   always_comb
   begin
      s_d      = s_q;
      s_d.done = 1'b0;
      if (clr)
      begin
         s_d.cnt = 3'h0;
      end
      else if (shift)
      begin
         s_d.sr  = {s_q.sr[6:0], din};
         s_d.cnt = s_q.cnt + 3'h1;
         if (s_q.cnt == 3'h7)
         begin
            s_d.byte_v = {s_q.sr[6:0], din};
            s_d.done   = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign byte_q = s_q.byte_v;
   assign done_q = s_q.done;
endmodule : dsh_shift8

/* design/dsh_host.sv */
`timescale 1ns/1ps
`include "dsh_consts.svh"
// ========================================
// host microcontroller end
module dsh_host
   import dsh_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // link
   dsh_link_if.host        link,
   // user request
   input  wire logic       req_valid,
   input  wire logic       req_data,
   input  wire logic [7:0] req_byte,
   input  wire logic       req_last,
   output logic            req_ready_q,
   output logic [7:0]      rx_byte_q,
   output logic            data_request_q
);
   typedef struct packed {
      dsh_host_st_t st;
      logic [3:0]   div;
      logic [3:0]   bitn;
      logic [7:0]   sr;
      logic         sclk;
      logic         sel;
      logic         sync;
      logic         last;
      logic [5:0]   chunk;
      logic [7:0]   rx;
      logic         rdy;
      logic         rq1;
      logic         rq2;
      logic         hw_n;
   } dsh_h_st_t;
   dsh_h_st_t h_q, h_d;

   // one byte at a time, clock low at rest
   always_comb
   begin
      h_d      = h_q;
      h_d.rq1  = link.data_request;
      h_d.rq2  = h_q.rq1;
      h_d.hw_n = 1'b1;
      h_d.rdy  = 1'b0;
      case (h_q.st)
         DSH_IDLE:
         begin
            h_d.sclk = 1'b0;
            if (req_valid && !h_q.rdy)
            begin
               if (!req_data)
               begin
                  h_d.sel = 1'b0;
                  h_d.st  = DSH_CMD;
               end
               else if (h_q.rq2 && h_q.chunk < `DSH_CHUNK_MAX)
               begin
                  h_d.sel   = 1'b1;
                  h_d.sync  = 1'b1;
                  h_d.chunk = h_q.chunk + 6'h1;
                  h_d.st    = DSH_DATA;
               end
               h_d.sr   = req_byte;
               h_d.last = req_last;
               h_d.bitn = 4'h0;
               h_d.div  = 4'h0;
            end
            if (!h_q.rq2)
               h_d.chunk = 6'h0;
            // deselect a cycle after the last falling clock edge, not with it
            if (h_q.rdy && h_q.last)
               h_d.sel = 1'b1;
         end
         default:
         begin
            h_d.div = h_q.div + 4'h1;
            if (h_q.div == `DSH_DIV_HALF)
            begin
               h_d.div  = 4'h0;
               h_d.sclk = ~h_q.sclk;
               if (!h_q.sclk)
                  h_d.rx = {h_q.rx[6:0], link.miso};
               else
               begin
                  h_d.sr   = {h_q.sr[6:0], 1'b0};
                  h_d.bitn = h_q.bitn + 4'h1;
                  if (h_q.bitn == 4'h5)
                     h_d.sync = 1'b0;
                  if (h_q.bitn == 4'h7)
                  begin
                     h_d.st  = DSH_IDLE;
                     h_d.rdy = 1'b1;
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         h_q     <= '0;
         h_q.st  <= DSH_IDLE;
         h_q.sel <= 1'b1;
      end
      else
         h_q <= h_d;
   end

   // only miso and data request are inputs
   assign link.sclk            = h_q.sclk;
   assign link.mosi            = h_q.sr[7];
   assign link.port_select_pin = h_q.sel;
   assign link.bit_sync        = h_q.sync;
   assign link.hw_reset_n_pin  = h_q.hw_n;
   assign req_ready_q          = h_q.rdy;
   assign rx_byte_q            = h_q.rx;
   assign data_request_q       = h_q.rq2;
endmodule : dsh_host

/* dv/dsh_link_sva.sv */
`timescale 1ns/1ps
// ========================================
// link checker
module dsh_link_sva
(
   // clocks and reset
   input wire logic clk,
   input wire logic clk_link,
   input wire logic rst,
   // link signals
   input wire logic sclk,
   input wire logic port_select_pin,
   input wire logic bit_sync,
   input wire logic data_request,
   input wire logic hw_reset_n_pin,
   input wire logic osc_out_pin,
   input wire logic osc_in_pin,
   input wire logic ctrl_select_n,
   input wire logic data_port_clock
);
   logic [13:0] wake_cnt_q;

   // link cycles since the reset pin was released, saturating
   always_ff @(posedge clk_link or posedge rst)
   begin
      if (rst)
         wake_cnt_q <= 14'h0;
      else if (!hw_reset_n_pin)
         wake_cnt_q <= 14'h0;
      else if (wake_cnt_q != 14'h3fff)
         wake_cnt_q <= wake_cnt_q + 14'h1;
   end

   osc_ground_a: assert property (@(posedge clk_link) disable iff (rst)
      !hw_reset_n_pin |-> !osc_out_pin && !osc_in_pin) else $error("oscillator pins not low");
   wake_quiet_a: assert property (@(posedge clk_link) disable iff (rst)
      wake_cnt_q < 14'd10000 |-> !data_request) else $error("request high too early");
   wake_raise_a: assert property (@(posedge clk_link) disable iff (rst)
      wake_cnt_q == 14'd10200 |-> data_request) else $error("request not raised in time");
   gate_block_a: assert property (@(posedge clk) disable iff (rst)
      !port_select_pin |-> !data_port_clock && !ctrl_select_n) else $error("data clock not gated");
   sclk_idle_a: assert property (@(posedge clk) disable iff (rst)
      $changed(port_select_pin) |-> !sclk) else $error("serial clock not resting low");
   sync_start_a: assert property (@(posedge clk) disable iff (rst)
      $rose(bit_sync) |-> port_select_pin && !sclk) else $error("sync raised mid bit");
   sync_end_a: assert property (@(posedge clk) disable iff (rst)
      $rose(bit_sync) |=> bit_sync [*4] ##[1:120] !bit_sync) else $error("sync not lowered");
   cmd_hold_a: assert property (@(posedge clk) disable iff (rst)
      $fell(port_select_pin) |=> !port_select_pin [*8]) else $error("command select too short");
endmodule : dsh_link_sva

/* dv/tb_decoder_serial_host_bringup.sv */
`timescale 1ns/1ps
`include "dsh_consts.svh"
// ========================================
// bench top
module tb_decoder_serial_host_bringup;
   logic        clk, clk_link, rst;
   logic        req_valid, req_data, req_last, req_ready_q, data_request_q;
   logic [7:0]  req_byte, rx_byte_q;
   logic        sine_active_q, layer12_enable_q, analog_pdown_q;
   logic [15:0] volume_q, rd_val;
   logic [31:0] cmd_sh;
   wire  [18:0] stat = {sine_active_q, layer12_enable_q, analog_pdown_q, volume_q};
   int          err_total, cmp_count;

   dsh_link_if link ();
   dsh_device u_dsh_device (.clk_link(clk_link), .link(link), .clk(clk), .rst(rst),
      .sine_active_q(sine_active_q), .layer12_enable_q(layer12_enable_q),
      .analog_pdown_q(analog_pdown_q), .volume_q(volume_q));
   dsh_host u_dsh_host (.clk(clk), .rst(rst), .link(link), .req_valid(req_valid),
      .req_data(req_data), .req_byte(req_byte), .req_last(req_last),
      .req_ready_q(req_ready_q), .rx_byte_q(rx_byte_q), .data_request_q(data_request_q));
   dsh_link_sva u_dsh_link_sva (.clk(clk), .clk_link(clk_link), .rst(rst), .sclk(link.sclk),
      .port_select_pin(link.port_select_pin), .bit_sync(link.bit_sync),
      .data_request(link.data_request), .hw_reset_n_pin(link.hw_reset_n_pin),
      .osc_out_pin(link.osc_out_pin), .osc_in_pin(link.osc_in_pin),
      .ctrl_select_n(link.ctrl_select_n), .data_port_clock(link.data_port_clock));

   // clocks, link clock with its own phase
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      clk_link = 1'b0;
      #2.3;
      forever #6 clk_link = ~clk_link;
   end

   // command bits seen on the wire, msb first
   always @(posedge link.sclk)
      if (!link.port_select_pin)
         cmd_sh <= {cmd_sh[30:0], link.mosi};

   // ========================================
   // helpers
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic stop_test();
      if (err_total == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   task automatic xfer(input logic dat, input logic [7:0] b, input logic last);
      int n;
      n = 0;
      while (dat && data_request_q !== 1'b1 && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      #1;
      req_valid = 1'b1;
      req_data  = dat;
      req_byte  = b;
      req_last  = last;
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      n = 0;
      while (req_ready_q !== 1'b1 && n < 500)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(req_ready_q, 1);
   endtask : xfer

   task automatic write_reg(input logic [7:0] addr, input logic [15:0] val);
      xfer(1'b0, `DSH_OP_WRITE, 1'b0);
      xfer(1'b0, addr, 1'b0);
      xfer(1'b0, val[15:8], 1'b0);
      xfer(1'b0, val[7:0], 1'b1);
      chk(cmd_sh, {`DSH_OP_WRITE, addr, val});
   endtask : write_reg

   task automatic read_reg(input logic [7:0] addr, output logic [15:0] v);
      xfer(1'b0, `DSH_OP_READ, 1'b0);
      xfer(1'b0, addr, 1'b0);
      xfer(1'b0, 8'h00, 1'b0);
      v[15:8] = rx_byte_q;
      xfer(1'b0, 8'h00, 1'b1);
      v[7:0] = rx_byte_q;
   endtask : read_reg

   task automatic send_data(input logic [63:0] v, input int cnt);
      for (int i = 0; i < cnt; i++)
         xfer(1'b1, v[63-8*i -: 8], 1'b0);
   endtask : send_data

   task automatic wait_stat(input logic [18:0] e);
      int n;
      n = 0;
      while (stat !== e && n < 300)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(stat, e);
   endtask : wait_stat

   // ========================================
   // scenarios
   task automatic t_wake();
      int n;
      n = 0;
      while (data_request_q !== 1'b1 && n < 20000)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(data_request_q, 1);
      chk(stat, {3'b001, `DSH_VOL_RESET});
   endtask : t_wake

   task automatic t_volume();
      write_reg(`DSH_ADDR_VOLUME, `DSH_VOL_FULL);
      wait_stat({3'b000, `DSH_VOL_FULL});
      write_reg(`DSH_ADDR_VOLUME, `DSH_VOL_PDOWN);
      wait_stat({3'b001, `DSH_VOL_PDOWN});
   endtask : t_volume

   task automatic t_read();
      write_reg(`DSH_ADDR_VOLUME, 16'ha2f5);
      wait_stat({3'b000, 16'ha2f5});
      read_reg(`DSH_ADDR_VOLUME, rd_val);
      chk(rd_val, 16'ha2f5);
   endtask : t_read

   task automatic t_mode();
      write_reg(`DSH_ADDR_MODE, 16'h0001 << `DSH_MODE_L12_BIT);
      wait_stat({3'b010, 16'ha2f5});
   endtask : t_mode

   task automatic t_sine();
      send_data(`DSH_SINE_ENTER, 8);
      wait_stat({3'b110, 16'ha2f5});
      send_data({24'h457869, 40'h0}, 3);
      write_reg(`DSH_ADDR_VOLUME, 16'h6974);
      send_data({8'h74, 56'h0}, 1);
      wait_stat({3'b010, 16'h6974});
   endtask : t_sine

   // main sequence
   initial
   begin
      rst       = 1'b1;
      req_valid = 1'b0;
      req_data  = 1'b0;
      req_byte  = 8'h00;
      req_last  = 1'b0;
      cmd_sh    = 32'h0;
      err_total = 0;
      cmp_count = 0;
      repeat (6) @(posedge clk);
      chk({link.osc_out_pin, link.osc_in_pin}, 0);
      #1;
      rst = 1'b0;
      t_wake();
      t_volume();
      t_read();
      t_mode();
      t_sine();
      stop_test();
   end

   // watchdog
   initial
   begin
      #400000;
      err_total++;
      stop_test();
   end
endmodule : tb_decoder_serial_host_bringup
